/* rtl/gfs_consts.svh */
// Constants and register map for the port line select and edge latch clear block
`ifndef GFS_CONSTS_SVH
`define GFS_CONSTS_SVH
`define GFS_OFS_RAW         12'h414
`define GFS_OFS_MASKED      12'h418
`define GFS_OFS_CLEAR       12'h41C
`define GFS_OFS_SELECT      12'h420
`define GFS_OFS_DATA        12'h430
`define GFS_OFS_DIR         12'h434
`define GFS_OFS_MASK        12'h438
`define GFS_OFS_SENSE       12'h43C
`define GFS_OFS_EVT         12'h440
`define GFS_OFS_EVT_MASK    12'h444
`define GFS_EVT_RAW_BIT     0
`define GFS_EVT_CLR_BIT     1
`define GFS_EVT_SEL_BIT     2
`define GFS_EVT_W           3
`define GFS_LINES           8
`define GFS_ZERO32          32'h0000_0000
`define GFS_ZERO8           8'h00
`define GFS_DIR_RESET       8'h00
`define GFS_SEL_RESET       8'h00
`endif

/* rtl/gfs_edge_detect.sv */
// Per-line trigger detector feeding the edge latches
`timescale 1ns/100ps
module gfs_edge_detect #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rstn_i,
   // Lines and sense
   input  wire logic [WIDTH-1:0] line_i,
   input  wire logic [WIDTH-1:0] sense_both_i,
   input  wire logic [WIDTH-1:0] sense_fall_i,
   // Trigger pulses
   output logic      [WIDTH-1:0] trig_o
);
   import gfs_pkg::*;

   // Armed stays low until the first clock edge after reset so a line already high
   // at release is not mistaken for a fresh edge
   typedef struct packed {
      logic             armed;
      logic [WIDTH-1:0] prev;
   } gfs_ed_state_t;

   gfs_ed_state_t st_q;
   gfs_ed_state_t st_d;

   always_comb begin
      st_d.prev  = line_i;
      st_d.armed = 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (sense_both_i[i]) begin
            trig_o[i] = line_i[i] ^ st_q.prev[i];
         end else if (sense_fall_i[i]) begin
            trig_o[i] = st_q.prev[i] & ~line_i[i];
         end else begin
            trig_o[i] = line_i[i] & ~st_q.prev[i];
         end
         trig_o[i] = trig_o[i] & st_q.armed;
      end
   end
endmodule

/* rtl/gfs_pkg.sv */
// Package of carrier types for the port line select block
package gfs_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gfs_bus_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gfs_pad_drive_t;

   typedef enum logic [1:0] {
      GFS_SENSE_RISE,
      GFS_SENSE_FALL,
      GFS_SENSE_BOTH,
      GFS_SENSE_HIGH
   } gfs_sense_t;
endpackage

/* rtl/gfs_port.sv */
// Port line function select, edge latch clear and interrupt status block
`timescale 1ns/100ps
`include "gfs_consts.svh"
module gfs_port #(
   parameter logic [7:0] SEL_RESET = `GFS_SEL_RESET,
   parameter logic [7:0] DIR_RESET = `GFS_DIR_RESET
) (
   // Clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   por_n_i,
   // Register port
   input  wire gfs_pkg::gfs_bus_req_t  bus_i,
   output logic                 [31:0] rdata_o,
   // Pads
   input  wire logic             [7:0] pad_in_i,
   output gfs_pkg::gfs_pad_drive_t     pad_o,
   // Peripherals
   input  wire gfs_pkg::gfs_pad_drive_t periph_i,
   output logic                  [7:0] periph_in_o,
   // Interrupts
   output logic                  [7:0] masked_irq_status_o,
   output logic                        port_irq_o,
   output logic                        evt_irq_o
);
   import gfs_pkg::*;

   typedef struct packed {
      logic [7:0]            line_function_select;
      logic [7:0]            line_direction;
      logic [7:0]            data_out;
      logic [7:0]            irq_mask;
      logic [7:0]            raw_irq_status;
      logic [15:0]           sense;
      logic [`GFS_EVT_W-1:0] evt;
      logic [`GFS_EVT_W-1:0] evt_mask;
      logic [31:0]           rdata;
   } gfs_state_t;

   gfs_state_t st_q;
   gfs_state_t st_d;
   logic [7:0] trig;
   logic [7:0] sense_both;
   logic [7:0] sense_fall;
   logic       rst_n;
   logic [7:0] clr_bits;

   // Power-on and external reset share one reset path
   assign rst_n = rstn_i & por_n_i;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [31:0] zext8(input logic [7:0] v);
      zext8 = {24'h00_0000, v};
   endfunction

   always_comb begin
      for (int i = 0; i < `GFS_LINES; i++) begin
         sense_both[i] = (st_q.sense[2*i +: 2] == GFS_SENSE_BOTH);
         sense_fall[i] = (st_q.sense[2*i +: 2] == GFS_SENSE_FALL);
      end
   end

   gfs_edge_detect #(
      .WIDTH (`GFS_LINES)
   ) u_edge (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rst_n),
      .line_i       (pad_in_i),
      .sense_both_i (sense_both),
      .sense_fall_i (sense_fall),
      .trig_o       (trig)
   );

   // Only ones clear; zeros leave the latch alone
   assign clr_bits = (bus_i.wr && hit(bus_i.addr, `GFS_OFS_CLEAR)) ? bus_i.wdata[7:0] : `GFS_ZERO8;

   always_comb begin
      st_d = st_q;
      st_d.rdata = `GFS_ZERO32;
      // Set wins over clear so a trigger in the clear cycle is kept
      for (int i = 0; i < `GFS_LINES; i++) begin
         if (trig[i]) begin
            st_d.raw_irq_status[i] = 1'b1;
         end else if (clr_bits[i]) begin
            st_d.raw_irq_status[i] = 1'b0;
         end
      end
      if (|(trig & ~st_q.raw_irq_status)) begin
         st_d.evt[`GFS_EVT_RAW_BIT] = 1'b1;
      end
      if (bus_i.wr) begin
         if (hit(bus_i.addr, `GFS_OFS_SELECT)) begin
            // Upper bits are dropped; they read back as zero
            st_d.line_function_select = bus_i.wdata[7:0];
            st_d.evt[`GFS_EVT_SEL_BIT] = 1'b1;
         end else if (hit(bus_i.addr, `GFS_OFS_CLEAR)) begin
            st_d.evt[`GFS_EVT_CLR_BIT] = 1'b1;
         end else if (hit(bus_i.addr, `GFS_OFS_DATA)) begin
            st_d.data_out = bus_i.wdata[7:0];
         end else if (hit(bus_i.addr, `GFS_OFS_DIR)) begin
            st_d.line_direction = bus_i.wdata[7:0];
         end else if (hit(bus_i.addr, `GFS_OFS_MASK)) begin
            st_d.irq_mask = bus_i.wdata[7:0];
         end else if (hit(bus_i.addr, `GFS_OFS_SENSE)) begin
            st_d.sense = bus_i.wdata[15:0];
         end else if (hit(bus_i.addr, `GFS_OFS_EVT_MASK)) begin
            st_d.evt_mask = bus_i.wdata[`GFS_EVT_W-1:0];
         end
      end
      if (bus_i.rd) begin
         if (hit(bus_i.addr, `GFS_OFS_RAW)) begin
            st_d.rdata = zext8(st_q.raw_irq_status);
         end else if (hit(bus_i.addr, `GFS_OFS_MASKED)) begin
            st_d.rdata = zext8(st_q.raw_irq_status & st_q.irq_mask);
         end else if (hit(bus_i.addr, `GFS_OFS_SELECT)) begin
            st_d.rdata = zext8(st_q.line_function_select);
         end else if (hit(bus_i.addr, `GFS_OFS_DATA)) begin
            st_d.rdata = zext8(pad_in_i);
         end else if (hit(bus_i.addr, `GFS_OFS_DIR)) begin
            st_d.rdata = zext8(st_q.line_direction);
         end else if (hit(bus_i.addr, `GFS_OFS_MASK)) begin
            st_d.rdata = zext8(st_q.irq_mask);
         end else if (hit(bus_i.addr, `GFS_OFS_SENSE)) begin
            st_d.rdata = {16'h0000, st_q.sense};
         end else if (hit(bus_i.addr, `GFS_OFS_EVT)) begin
            st_d.rdata = {29'h0000_0000, st_q.evt};
            // Read clears, but a raw latch event landing now still sets its bit
            st_d.evt = `GFS_EVT_W'(0);
            if (|(trig & ~st_q.raw_irq_status)) begin
               st_d.evt[`GFS_EVT_RAW_BIT] = 1'b1;
            end
         end else if (hit(bus_i.addr, `GFS_OFS_EVT_MASK)) begin
            st_d.rdata = {29'h0000_0000, st_q.evt_mask};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q                      <= '0;
         // Ordinary lines to software, debug lines keep their test-port role
         st_q.line_function_select <= SEL_RESET;
         // Inputs unless the line defaults to peripheral control and its DIR_RESET bit is set
         st_q.line_direction       <= DIR_RESET & SEL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Selected lines follow the peripheral, others the software registers
   always_comb begin
      for (int i = 0; i < `GFS_LINES; i++) begin
         if (st_q.line_function_select[i]) begin
            pad_o.out[i] = periph_i.out[i];
            pad_o.oe[i]  = periph_i.oe[i];
         end else begin
            pad_o.out[i] = st_q.data_out[i];
            pad_o.oe[i]  = st_q.line_direction[i];
         end
      end
   end

   // Peripherals see zero while their line is in software mode
   assign periph_in_o         = pad_in_i & st_q.line_function_select;
   assign masked_irq_status_o = st_q.raw_irq_status & st_q.irq_mask;
   assign port_irq_o          = |masked_irq_status_o;
   assign evt_irq_o           = |(st_q.evt & st_q.evt_mask);
   assign rdata_o             = st_q.rdata;
endmodule

/* sim/gfs_port_chk.sv */
// Assertion checker for the port line select block
`timescale 1ns/100ps
module gfs_port_chk #(
   parameter logic [7:0] SEL_RESET = 8'h00
) (
   // Clock and reset
   input wire logic                    ref_clk_i,
   input wire logic                    rstn_i,
   input wire logic                    por_n_i,
   // Register port
   input wire gfs_pkg::gfs_bus_req_t   bus_i,
   input wire logic             [31:0] rdata_o,
   // Pads and peripherals
   input wire logic              [7:0] pad_in_i,
   input wire gfs_pkg::gfs_pad_drive_t pad_o,
   input wire gfs_pkg::gfs_pad_drive_t periph_i,
   input wire logic              [7:0] periph_in_o,
   // Interrupts
   input wire logic              [7:0] masked_irq_status_o,
   input wire logic                    port_irq_o,
   input wire logic                    evt_irq_o
);
   import gfs_pkg::*;
   wire rst_n = rstn_i & por_n_i;
   logic [7:0] sel_q;
   // Shadow of the select register, so routing can be judged without the body
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) sel_q <= SEL_RESET;
      else if (bus_i.wr && bus_i.addr == 12'h420) sel_q <= bus_i.wdata[7:0];
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);
   a_irq_or_masked: assert property (port_irq_o == (|masked_irq_status_o))
      else $error("port irq is not the OR of masked status");
   a_sel_routes_in: assert property (periph_in_o == (pad_in_i & sel_q))
      else $error("peripheral input routing wrong");
   a_sel_drives_pad: assert property ((({pad_o} ^ {periph_i}) & {sel_q, sel_q}) == 16'h0000)
      else $error("selected pad not driven by peripheral");
   a_sel_readback: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 12'h420 |-> rdata_o == {24'h0, sel_q})
      else $error("select readback wrong");
   a_clear_ones: assert property (bus_i.wr && bus_i.addr == 12'h41C && pad_in_i == $past(pad_in_i)
      |=> (masked_irq_status_o & $past(bus_i.wdata[7:0])) == 8'h00)
      else $error("cleared latch still set");
   a_zero_keeps: assert property (bus_i.wr && bus_i.addr == 12'h41C
      |=> ($past(masked_irq_status_o) & ~$past(bus_i.wdata[7:0]) & ~masked_irq_status_o) == 8'h00)
      else $error("latch lost without a clear bit");
   a_raw_holds: assert property (!bus_i.wr && pad_in_i == $past(pad_in_i) |=> $stable(masked_irq_status_o))
      else $error("status changed without cause");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !port_irq_o && rdata_o == 32'h0)
      else $error("outputs active during reset");
endmodule
bind gfs_port gfs_port_chk #(.SEL_RESET(SEL_RESET)) chk_u (.ref_clk_i, .rstn_i, .por_n_i, .bus_i, .rdata_o,
   .pad_in_i, .pad_o, .periph_i, .periph_in_o, .masked_irq_status_o, .port_irq_o, .evt_irq_o);

/* sim/tb.sv */
// Self-checking bench for the port line select block
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("BAD %0t mismatch", $time); end end
module tb;
   import gfs_pkg::*;
   logic           ref_clk_i = 1'b0;
   logic           rstn_i = 1'b0;
   logic           por_n_i = 1'b0;
   gfs_bus_req_t   bus_i = '0;
   logic [7:0]     pad_in_i = 8'h00;
   gfs_pad_drive_t periph_i = '{8'h33, 8'hC3};
   gfs_pad_drive_t pad_o;
   logic [31:0]    rdata_o;
   logic [7:0]     periph_in_o;
   logic [7:0]     masked_irq_status_o;
   logic           port_irq_o;
   logic           evt_irq_o;
   int             fails = 0;
   int             compares = 0;
   int             cyc = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   gfs_port #(.SEL_RESET(8'h0F)) dut_u (.ref_clk_i, .rstn_i, .por_n_i, .bus_i, .rdata_o, .pad_in_i, .pad_o,
      .periph_i, .periph_in_o, .masked_irq_status_o, .port_irq_o, .evt_irq_o);
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk_i);
      bus_i <= '0;
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      bus_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk_i);
      bus_i <= '0;
      #1 `CHK(rdata_o, e)
   endtask
   task automatic report_and_stop;
      if (fails == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_select;
      @(posedge ref_clk_i);
      pad_in_i <= 8'h3C;
      wr(12'h420, 32'hFFFF_FF5A);
      rdc(12'h420, 32'h5A);
      wr(12'h430, 32'hFF);
      wr(12'h434, 32'h0F);
      `CHK({pad_o}, {8'h12 | 8'hA5, 8'h42 | 8'h05})
      `CHK(periph_in_o, 8'h18)
      wr(12'h7FC, 32'hFFFF_FFFF);
      rdc(12'h7FC, 32'h0);
   endtask
   task automatic t_irq;
      wr(12'h438, 32'hFF);
      wr(12'h41C, 32'hFF);
      `CHK(masked_irq_status_o, 8'h00)
      @(posedge ref_clk_i);
      pad_in_i <= 8'hFF;
      repeat (3) @(posedge ref_clk_i);
      rdc(12'h414, 32'hC3);
      `CHK(port_irq_o, 1'b1)
      wr(12'h41C, 32'h03);
      `CHK(masked_irq_status_o, 8'hC0)
      wr(12'h438, 32'h40);
      rdc(12'h418, 32'h40);
      rdc(12'h414, 32'hC0);
      wr(12'h41C, 32'hC0);
      `CHK(port_irq_o, 1'b0)
      `CHK(evt_irq_o, 1'b0)
      wr(12'h43C, 32'h6);
      @(posedge ref_clk_i);
      pad_in_i <= 8'hFC;
      repeat (3) @(posedge ref_clk_i);
      rdc(12'h414, 32'h3);
      wr(12'h444, 32'h7);
      `CHK(evt_irq_o, 1'b1)
      rdc(12'h440, 32'h7);
      `CHK(evt_irq_o, 1'b0)
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      por_n_i <= 1'b1;
      rdc(12'h420, 32'h0F);
      rdc(12'h434, 32'h0);
      rdc(12'h414, 32'h0);
      t_select;
      t_irq;
      @(posedge ref_clk_i);
      por_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      por_n_i <= 1'b1;
      rdc(12'h420, 32'h0F);
      rdc(12'h434, 32'h0);
      rdc(12'h414, 32'h0);
      report_and_stop;
   end
endmodule
